// *** inc/acs_pkg.sv ***
// acs types: controller state and packed state records
`include "acs_regs.svh"
package acs_pkg;

  typedef enum logic [1:0] {ACS_IDLE, ACS_ARMED, ACS_CONV} acs_state_t;

  typedef struct packed {
    logic [`ACS_DIV_W-1:0] cnt;
    logic tick;
  } acs_div_t;

  typedef struct packed {
    logic [`ACS_CH_W-1:0] sel_ch;
    logic [`ACS_REF_W-1:0] sel_ref;
    logic [`ACS_CH_W-1:0] applied_ch;
    logic [`ACS_REF_W-1:0] applied_ref;
    logic en;
    logic auto_trig;
    logic free_run;
    logic [`ACS_DIV_SEL_W-1:0] div_sel;
    acs_state_t st;
    logic [`ACS_CNT_W-1:0] cnt;
    logic [`ACS_CNT_W-1:0] len;
    logic ext_pend;
    logic [`ACS_RES_W-1:0] dac;
    logic hold;
    logic [`ACS_RES_W-1:0] result;
    logic done;
    logic sleep_conv;
    logic [`ACS_NIRQ-1:0] ist;
    logic [`ACS_NIRQ-1:0] ien;
    logic [`ACS_DW-1:0] rdata;
    logic irq;
    logic trg_s1;
    logic trg_s2;
    logic trg_d;
    logic comp_s1;
    logic comp_s2;
    logic slp_d;
  } acs_core_t;

endpackage : acs_pkg

// *** inc/acs_regs.svh ***
// acs register map, field positions, reset values and timing counts
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************
// register port geometry
// ****************************************
`define ACS_AW 3
`define ACS_DW 16

// ****************************************
// register offsets
// ****************************************
`define ACS_OFF_SEL 3'h0
`define ACS_OFF_CSA 3'h1
`define ACS_OFF_TRG 3'h2
`define ACS_OFF_RES 3'h3
`define ACS_OFF_IST 3'h4
`define ACS_OFF_ICL 3'h5
`define ACS_OFF_IEN 3'h6

// ****************************************
// selection_register fields
// ****************************************
`define ACS_CH_W 6
`define ACS_REF_W 3
`define ACS_SEL_CH_LSB 0
`define ACS_SEL_CH_MSB 5
`define ACS_SEL_REF_LSB 6
`define ACS_SEL_REF_MSB 8
`define ACS_CH_RESET 6'h00
`define ACS_REF_RESET 3'h0

// ****************************************
// control_status_a and trigger fields
// ****************************************
`define ACS_CSA_EN 0
`define ACS_CSA_START 1
`define ACS_CSA_AUTO 2
`define ACS_CSA_DONE 3
`define ACS_CSA_DIV_LSB 4
`define ACS_CSA_DIV_MSB 6
`define ACS_DIV_SEL_W 3
`define ACS_DIV_RESET 3'h2
`define ACS_TRG_FREE 0

// ****************************************
// interrupt status bits
// ****************************************
`define ACS_NIRQ 2
`define ACS_IRQ_DONE 0
`define ACS_IRQ_SLEEP 1

// ****************************************
// conversion timing in converter clocks
// ****************************************
`define ACS_CNT_W 5
`define ACS_LEN_NORMAL 5'h0d
`define ACS_LEN_EXTENDED 5'h19
`define ACS_SAMPLE_END 5'h0c
`define ACS_FIRST_DEC 5'h0b
`define ACS_LAST_DEC 5'h02
`define ACS_CNT_ONE 5'h01
`define ACS_RES_W 10
`define ACS_DAC_MID 10'h200
`define ACS_DIV_W 7

`endif

// *** logic/acs_ctrl.sv ***
// acs_ctrl: converter selection buffer, conversion start, sleep start and interrupts
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_ctrl (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // register port
  input wire logic [`ACS_AW-1:0] ADDR,
  input wire logic [`ACS_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`ACS_DW-1:0] RDATA,
  // cpu sleep state, high while halted in idle or noise-reduction sleep
  input wire logic SLEEP_QUIET,
  // external auto-trigger source
  input wire logic TRIG_PIN,
  // analog converter side
  input wire logic COMP_HIGH,
  output logic [`ACS_CH_W-1:0] APPLIED_CH,
  output logic [`ACS_REF_W-1:0] APPLIED_REF,
  output logic [`ACS_RES_W-1:0] DAC_CODE,
  output logic SAMPLE_HOLD,
  // interrupt
  output logic IRQ
);
  import acs_pkg::*;

  acs_core_t r;
  acs_core_t next_r;
  logic tick;
  logic div_restart;
  logic csa_wr;
  logic sel_wr;
  logic last_tick;
  logic trig_edge;
  logic sleep_edge;
  logic [`ACS_CNT_W-1:0] idx;
  logic [`ACS_CH_W-1:0] wr_ch;
  logic [`ACS_REF_W-1:0] wr_ref;

  // ****************************************
  // converter clock
  // ****************************************
  acs_prescale u_prescale (
    .clk(REF_CLK),
    .nrst(NRST),
    .run(r.en),
    .restart(div_restart),
    .div_sel(r.div_sel),
    .tick(tick)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  assign csa_wr = WR && (ADDR == `ACS_OFF_CSA);
  assign sel_wr = WR && (ADDR == `ACS_OFF_SEL);
  assign wr_ch = WDATA[`ACS_SEL_CH_MSB:`ACS_SEL_CH_LSB];
  assign wr_ref = WDATA[`ACS_SEL_REF_MSB:`ACS_SEL_REF_LSB];
  assign last_tick = (r.st == ACS_CONV) && tick && (r.cnt == r.len);
  assign trig_edge = r.trg_s2 && !r.trg_d;
  assign sleep_edge = SLEEP_QUIET && !r.slp_d;
  assign idx = r.len - `ACS_LAST_DEC - r.cnt;
  assign div_restart = r.en && r.auto_trig && !r.free_run && trig_edge
                       && (r.st == ACS_IDLE);

  always_comb begin
    next_r = r;
    // pin synchronisers
    next_r.trg_s1 = TRIG_PIN;
    next_r.trg_s2 = r.trg_s1;
    next_r.trg_d = r.trg_s2;
    next_r.comp_s1 = COMP_HIGH;
    next_r.comp_s2 = r.comp_s1;
    next_r.slp_d = SLEEP_QUIET;

    // applied selection follows the buffer except while locked
    if ((r.st != ACS_CONV) || (r.cnt == r.len)) begin
      next_r.applied_ch = r.sel_ch;
      next_r.applied_ref = r.sel_ref;
    end // otherwise held

    // register writes
    if (sel_wr) begin
      next_r.sel_ch = wr_ch;
      next_r.sel_ref = wr_ref;
    end
    if (csa_wr) begin
      next_r.en = WDATA[`ACS_CSA_EN];
      next_r.auto_trig = WDATA[`ACS_CSA_AUTO];
      next_r.div_sel = WDATA[`ACS_CSA_DIV_MSB:`ACS_CSA_DIV_LSB];
      if (WDATA[`ACS_CSA_DONE]) begin
        next_r.done = 1'b0;
      end
      if (WDATA[`ACS_CSA_START] && (r.st == ACS_IDLE)) begin
        next_r.st = ACS_ARMED;
      end
    end
    if (WR && (ADDR == `ACS_OFF_TRG)) begin
      next_r.free_run = WDATA[`ACS_TRG_FREE];
    end
    if (WR && (ADDR == `ACS_OFF_ICL)) begin
      next_r.ist = r.ist & ~WDATA[`ACS_NIRQ-1:0];
    end
    if (WR && (ADDR == `ACS_OFF_IEN)) begin
      next_r.ien = WDATA[`ACS_NIRQ-1:0];
    end

    // automatic starts only from an idle converter
    if (div_restart) begin
      next_r.st = ACS_ARMED;
    end
    if (sleep_edge && r.en && (r.st == ACS_IDLE)) begin
      next_r.st = ACS_ARMED;
      next_r.sleep_conv = 1'b1;
    end

    // conversion sequencing on converter ticks
    unique case (r.st)
      ACS_IDLE: begin
      end
      ACS_ARMED: begin
        if (tick) begin
          next_r.st = ACS_CONV;
          next_r.cnt = `ACS_CNT_ONE;
          next_r.len = r.ext_pend ? `ACS_LEN_EXTENDED : `ACS_LEN_NORMAL;
          next_r.ext_pend = 1'b0;
          next_r.hold = 1'b1;
          next_r.dac = '0;
        end
      end
      ACS_CONV: begin
        if (tick) begin
          next_r.cnt = r.cnt + `ACS_CNT_ONE;
          if (r.cnt == r.len - `ACS_SAMPLE_END) begin
            next_r.hold = 1'b0;
            next_r.dac = `ACS_DAC_MID;
          end
          // successive approximation, all ones when input exceeds reference
          if ((r.cnt >= r.len - `ACS_FIRST_DEC) &&
              (r.cnt <= r.len - `ACS_LAST_DEC)) begin
            if (!r.comp_s2) begin
              next_r.dac[idx[3:0]] = 1'b0;
            end
            if (idx != '0) begin
              next_r.dac[idx[3:0] - 4'h1] = 1'b1;
            end
          end
          if (r.cnt == r.len) begin
            next_r.result = r.dac;
            next_r.done = 1'b1;
            next_r.ist[`ACS_IRQ_DONE] = 1'b1;
            if (r.sleep_conv) begin
              next_r.ist[`ACS_IRQ_SLEEP] = 1'b1;
            end
            next_r.sleep_conv = 1'b0;
            if (r.auto_trig && r.free_run) begin
              // restart uses the selection copied in the last cycle
              next_r.cnt = `ACS_CNT_ONE;
              next_r.len = r.ext_pend ? `ACS_LEN_EXTENDED : `ACS_LEN_NORMAL;
              next_r.ext_pend = 1'b0;
              next_r.hold = 1'b1;
              next_r.dac = '0;
            end else begin
              next_r.st = ACS_IDLE;
            end
          end
        end
      end
    endcase

    // a changed reference lengthens the following conversion
    if (sel_wr && (wr_ref != r.sel_ref)) begin
      next_r.ext_pend = 1'b1;
    end

    // only software clearing enable stops the converter, sleep does not
    if (!next_r.en) begin
      next_r.st = ACS_IDLE;
      next_r.hold = 1'b0;
      next_r.ext_pend = 1'b1;
      next_r.sleep_conv = 1'b0;
    end

    next_r.irq = |(next_r.ist & next_r.ien);

    // read data stands one cycle only
    next_r.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        `ACS_OFF_SEL: begin
          next_r.rdata[`ACS_SEL_CH_MSB:`ACS_SEL_CH_LSB] = r.sel_ch;
          next_r.rdata[`ACS_SEL_REF_MSB:`ACS_SEL_REF_LSB] = r.sel_ref;
        end
        `ACS_OFF_CSA: begin
          next_r.rdata[`ACS_CSA_EN] = r.en;
          next_r.rdata[`ACS_CSA_START] = (r.st != ACS_IDLE);
          next_r.rdata[`ACS_CSA_AUTO] = r.auto_trig;
          next_r.rdata[`ACS_CSA_DONE] = r.done;
          next_r.rdata[`ACS_CSA_DIV_MSB:`ACS_CSA_DIV_LSB] = r.div_sel;
        end
        `ACS_OFF_TRG: begin
          next_r.rdata[`ACS_TRG_FREE] = r.free_run;
        end
        `ACS_OFF_RES: begin
          next_r.rdata[`ACS_RES_W-1:0] = r.result;
        end
        `ACS_OFF_IST: begin
          next_r.rdata[`ACS_NIRQ-1:0] = r.ist;
        end
        `ACS_OFF_IEN: begin
          next_r.rdata[`ACS_NIRQ-1:0] = r.ien;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.sel_ch <= `ACS_CH_RESET;
      r.sel_ref <= `ACS_REF_RESET;
      r.applied_ch <= `ACS_CH_RESET;
      r.applied_ref <= `ACS_REF_RESET;
      r.div_sel <= `ACS_DIV_RESET;
      r.st <= ACS_IDLE;
      r.ext_pend <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign RDATA = r.rdata;
  assign APPLIED_CH = r.applied_ch;
  assign APPLIED_REF = r.applied_ref;
  assign DAC_CODE = r.dac;
  assign SAMPLE_HOLD = r.hold;
  assign IRQ = r.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  property p_track;
    (r.st == ACS_IDLE) |=> (APPLIED_CH == $past(r.sel_ch)) &&
                           (APPLIED_REF == $past(r.sel_ref));
  endproperty
  a_track: assert property (p_track) else $error("idle selection not tracked");

  property p_lock;
    (r.st == ACS_CONV && r.cnt != r.len) |=> $stable(APPLIED_CH) && $stable(APPLIED_REF);
  endproperty
  a_lock: assert property (p_lock) else $error("selection moved mid conversion");

  property p_resume;
    (r.st == ACS_CONV && r.cnt == r.len) |=> (APPLIED_CH == $past(r.sel_ch));
  endproperty
  a_resume: assert property (p_resume) else $error("no tracking in last cycle");

  property p_wait;
    (r.st == ACS_ARMED && !tick) |=> (r.st != ACS_CONV);
  endproperty
  a_wait: assert property (p_wait) else $error("conversion began without tick");

  property p_done;
    last_tick |=> r.done && (r.result == $past(r.dac)) && r.ist[`ACS_IRQ_DONE];
  endproperty
  a_done: assert property (p_done) else $error("completion not recorded");

  property p_free;
    (last_tick && r.en && r.auto_trig && r.free_run && !csa_wr) |=>
      (r.st == ACS_CONV) && (r.cnt == `ACS_CNT_ONE);
  endproperty
  a_free: assert property (p_free) else $error("free run did not restart");

  property p_sleep;
    (sleep_edge && r.en && r.st == ACS_IDLE && !csa_wr) |=>
      (r.st == ACS_ARMED) && r.sleep_conv;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep start missed");

  property p_wake;
    (last_tick && r.sleep_conv) |=>
      r.ist[`ACS_IRQ_SLEEP] && (IRQ || !r.ien[`ACS_IRQ_SLEEP]);
  endproperty
  a_wake: assert property (p_wake) else $error("sleep completion not flagged");

  property p_ext;
    (sel_wr && wr_ref != r.sel_ref && r.st != ACS_ARMED) |=> r.ext_pend;
  endproperty
  a_ext: assert property (p_ext) else $error("reference change not extended");

  property p_rdsel;
    (RD && ADDR == `ACS_OFF_SEL) |=>
      (RDATA[`ACS_SEL_REF_MSB:`ACS_SEL_CH_LSB] == $past({r.sel_ref, r.sel_ch}));
  endproperty
  a_rdsel: assert property (p_rdsel) else $error("selection read wrong");

  property p_buf;
    sel_wr |=> (r.sel_ch == $past(wr_ch)) && (r.sel_ref == $past(wr_ref));
  endproperty
  a_buf: assert property (p_buf) else $error("selection buffer not written");

  property p_keep_en;
    (r.en && !csa_wr) |=> r.en;
  endproperty
  a_keep_en: assert property (p_keep_en) else $error("converter disabled by itself");

  property p_clear;
    (last_tick && !(r.auto_trig && r.free_run)) |=> (r.st == ACS_IDLE);
  endproperty
  a_clear: assert property (p_clear) else $error("start bit not cleared");

  c_sleep: cover property (last_tick && r.sleep_conv);
  c_free: cover property (last_tick && r.auto_trig && r.free_run);
  c_ext: cover property ((r.st == ACS_CONV) && (r.len == `ACS_LEN_EXTENDED) && last_tick);
  c_trig: cover property (div_restart);

endmodule : acs_ctrl

// *** logic/acs_prescale.sv ***
// acs converter clock prescaler: one-cycle enable pulse every 2^(div_sel+1) cycles, 128 cycles at div_sel 7
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_prescale (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic [`ACS_DIV_SEL_W-1:0] div_sel,
  // converter clock enable
  output logic tick
);
  import acs_pkg::*;

  acs_div_t r;
  acs_div_t next_r;
  logic [`ACS_DIV_W-1:0] last;

  always_comb begin
    last = (`ACS_DIV_W'(2) << div_sel) - `ACS_DIV_W'(1);
    next_r = r;
    next_r.tick = 1'b0;
    // held in reset while the converter is off or a trigger restarts it
    if (!run || restart) begin
      next_r.cnt = '0;
    end else if (r.cnt == last) begin
      next_r.cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + `ACS_DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule : acs_prescale

// *** verif/acs_analog.sv ***
// acs analog front end model: input level held at sampling, compared with the trial code
`timescale 1ns/10ps
`include "acs_regs.svh"
module acs_analog (
  // converter side
  input wire logic sample_hold,
  input wire logic [`ACS_RES_W-1:0] dac_code,
  output logic comp_high,
  // stimulus level, values above 10'h3ff lie over the reference
  input wire logic [`ACS_RES_W:0] vin
);
  logic [`ACS_RES_W:0] held = '0;

  // track while sampling, keep the level once the sample phase ends
  always @(sample_hold or vin) begin
    if (sample_hold) begin
      held = vin;
    end
  end

  assign comp_high = (held >= {1'b0, dac_code});
endmodule : acs_analog

// *** verif/tb.sv ***
// acs testbench: selection buffer, conversions, sleep start, trigger and free running
`timescale 1ns/10ps
`include "acs_regs.svh"
module tb;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [`ACS_AW-1:0] ADDR = '0;
  logic [`ACS_DW-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLEEP_QUIET = 1'b0;
  logic TRIG_PIN = 1'b0;
  logic COMP_HIGH;
  logic [`ACS_DW-1:0] RDATA;
  logic [`ACS_CH_W-1:0] APPLIED_CH;
  logic [`ACS_REF_W-1:0] APPLIED_REF;
  logic [`ACS_RES_W-1:0] DAC_CODE;
  logic SAMPLE_HOLD;
  logic IRQ;
  logic [`ACS_RES_W:0] vin = '0;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h6a9b;
  int n;
  int i;
  int lens [4];
  logic [15:0] d;
  logic [5:0] ch;
  logic [5:0] nch;
  logic [2:0] rf;

  always #5 REF_CLK = ~REF_CLK;

  acs_ctrl acs_ctrl_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SLEEP_QUIET(SLEEP_QUIET), .TRIG_PIN(TRIG_PIN), .COMP_HIGH(COMP_HIGH),
    .APPLIED_CH(APPLIED_CH), .APPLIED_REF(APPLIED_REF), .DAC_CODE(DAC_CODE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .IRQ(IRQ)
  );

  acs_analog acs_analog_i (
    .sample_hold(SAMPLE_HOLD), .dac_code(DAC_CODE), .comp_high(COMP_HIGH), .vin(vin)
  );

  // ****************************************
  // expectations and bus tasks
  // ****************************************
  function automatic logic [15:0] exp_res(input logic [10:0] v);
    return (v > 11'h3ff) ? 16'h03ff : {6'h00, v[9:0]};
  endfunction : exp_res

  function automatic logic [15:0] sel_word(input logic [5:0] c, input logic [2:0] r);
    return {7'h00, r, c};
  endfunction : sel_word

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge REF_CLK);
    #1;
  endtask : cyc

  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : rd

  // wait for sample phase (w=1) or interrupt (w=0), counting cycles
  task wt(input bit w, output int cnt);
    cnt = 0;
    while (((w ? SAMPLE_HOLD : IRQ) !== 1'b1) && cnt < 400) begin
      cyc(1);
      cnt++;
    end
    if (cnt >= 400) begin
      bad_count++;
      $display("MISMATCH t=%0t wait ran out", $time);
      tally_and_finish;
    end
  endtask : wt

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(`ACS_OFF_SEL, d);
    chk(d, 16'h0000);
    rd(`ACS_OFF_CSA, d);
    chk(d, 16'h0020);
    rd(3'h7, d);
    chk(d, 16'h0000);
    chk(IRQ, 1'b0);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      ch = 6'($random(seed));
      nch = ~ch;
      // each reference serves two conversions, so a result after a switch is never the only one
      rf = i[1] ? 3'h2 : 3'h5;
      vin = (i == 0) ? 11'h500 : {1'b0, 10'($random(seed))};
      wr(`ACS_OFF_SEL, sel_word(ch, rf));
      cyc(2);
      chk(APPLIED_CH, ch);
      chk(APPLIED_REF, rf);
      wr(`ACS_OFF_IEN, 16'h0003);
      wr(`ACS_OFF_CSA, 16'h0023);
      #1 chk(SAMPLE_HOLD, 1'b0);
      wt(1'b1, n);
      chk(DAC_CODE, 16'h0000);
      // one converter clock after the sample phase begins before reselecting
      cyc(8);
      wr(`ACS_OFF_SEL, sel_word(nch, rf));
      cyc(2);
      chk(APPLIED_CH, ch);
      rd(`ACS_OFF_SEL, d);
      chk(d, sel_word(nch, rf));
      wt(1'b0, lens[i]);
      chk(APPLIED_CH, nch);
      rd(`ACS_OFF_RES, d);
      chk(d, exp_res(vin));
      rd(`ACS_OFF_CSA, d);
      chk(d, 16'h0029);
      wr(`ACS_OFF_IEN, 16'h0000);
      cyc(2);
      chk(IRQ, 1'b0);
      wr(`ACS_OFF_IEN, 16'h0003);
      cyc(2);
      chk(IRQ, 1'b1);
      wr(`ACS_OFF_ICL, 16'h0003);
      wr(`ACS_OFF_CSA, 16'h0029);
      cyc(2);
      chk(IRQ, 1'b0);
      rd(`ACS_OFF_IST, d);
      chk(d, 16'h0000);
    end
    chk(16'(lens[0] - lens[1]), 16'h0060);
    chk(16'(lens[2] - lens[3]), 16'h0060);
    $display("test single conversions done");
    vin = {1'b0, 10'($random(seed))};
    // converter enabled and idle, single mode, completion interrupt enabled
    SLEEP_QUIET <= 1'b1;
    wt(1'b1, n);
    // another wake source ends the sleep before the conversion completes
    SLEEP_QUIET <= 1'b0;
    wt(1'b0, n);
    rd(`ACS_OFF_IST, d);
    chk(d, 16'h0003);
    rd(`ACS_OFF_RES, d);
    chk(d, exp_res(vin));
    rd(`ACS_OFF_CSA, d);
    chk(d[0], 1'b1);
    wr(`ACS_OFF_ICL, 16'h0003);
    wr(`ACS_OFF_CSA, 16'h0029);
    $display("test sleep start done");
    wr(`ACS_OFF_TRG, 16'h0000);
    wr(`ACS_OFF_CSA, 16'h0025);
    TRIG_PIN <= 1'b1;
    wt(1'b1, n);
    TRIG_PIN <= 1'b0;
    cyc(4);
    TRIG_PIN <= 1'b1;
    // reselect during the conversion, a converter clock after the sample phase begins
    cyc(4);
    wr(`ACS_OFF_SEL, sel_word(ch, rf));
    wt(1'b0, n);
    chk(APPLIED_CH, ch);
    wr(`ACS_OFF_ICL, 16'h0003);
    cyc(40);
    chk(SAMPLE_HOLD, 1'b0);
    TRIG_PIN <= 1'b0;
    $display("test auto trigger done");
    wr(`ACS_OFF_TRG, 16'h0001);
    wr(`ACS_OFF_CSA, 16'h002f);
    wt(1'b0, n);
    wr(`ACS_OFF_ICL, 16'h0003);
    wt(1'b1, n);
    // the change lands a converter clock after the automatic restart
    cyc(8);
    wr(`ACS_OFF_SEL, sel_word(nch ^ 6'h15, rf));
    cyc(2);
    chk(APPLIED_CH, ch);
    wt(1'b0, n);
    chk(APPLIED_CH, nch ^ 6'h15);
    // converter off before any deeper sleep
    wr(`ACS_OFF_CSA, 16'h0020);
    $display("test free running done");
    tally_and_finish;
  end
endmodule : tb
